// ### hdl/led_sink_shift_latch.sv
// Purpose: Serial shift register, latch and sink drive with diagnostics
// Assumes: Pins are asynchronous and slower than a quarter of clock_i
// Notes:   Serial clock, strobe and gate are sampled, not used as clocks
`timescale 1ns/10ps
`include "lsl_consts.svh"
`default_nettype none

module led_sink_shift_latch #(
    parameter int BUF_DEPTH = `LSL_BUF_DEPTH
) (
    input  wire logic                       clock_i,       // 25 MHz clock
    input  wire logic                       nrst_i,        // Reset, low
    input  wire logic                       serial_in_i,   // Serial data
    input  wire logic                       serial_clock_i,// Serial clock
    input  wire logic                       latch_strobe_i,// Load strobe
    input  wire logic                       drive_gate_n_i,// Gate, low on
    input  wire logic                       error_mode_i,  // Enter diag
    input  wire logic                       overtemp_i,    // Hot sense
    input  wire logic [`LSL_CHANNELS-1:0]   open_sense_i,  // Open LED
    input  wire logic [`LSL_CHANNELS-1:0]   short_sense_i, // Shorted LED
    input  wire logic                       sink_ready_i,  // Driver accepts
    output logic      [`LSL_CHANNELS-1:0]   sink_channel_o,// Sink enables
    output logic                            chain_out_o,   // Serial out
    output logic                            low_current_o, // Reduced Iout
    output lsl_pkg::diag_mode_t             mode_o,        // Current mode
    output lsl_pkg::diag_result_t           diag_result_o, // Fault detail
    output logic                            global_fault_o,// Any fault
    output logic                            overrun_o      // Load dropped
);

    localparam int NCH = `LSL_CHANNELS;

    lsl_pkg::pin_bundle_t   pins_raw;
    lsl_pkg::pin_bundle_t   pins_rst;
    lsl_pkg::pin_bundle_t   pins;
    logic                   sclk_prev_q;
    logic                   strobe_prev_q;
    logic                   sclk_rise;
    logic                   sclk_fall;
    logic                   strobe_rise;
    logic [NCH-1:0]         shift_q;
    logic                   spill_q;
    logic                   chain_q;
    logic [NCH-1:0]         data_q;
    logic [NCH-1:0]         sink_q;
    logic                   low_cur_q;
    logic                   global_fault_q;
    logic                   overrun_q;
    lsl_pkg::diag_mode_t    mode_q;
    lsl_pkg::diag_result_t  result_q;
    logic                   buf_in_ready;
    logic                   buf_out_valid;
    logic [NCH-1:0]         buf_out_data;
    logic                   any_fault;

    // Next diagnostic mode in the stepping order
    function automatic lsl_pkg::diag_mode_t next_mode(
        input lsl_pkg::diag_mode_t m
    );
        unique case (m)
            lsl_pkg::MODE_NORMAL:      next_mode = lsl_pkg::MODE_GLOBAL;
            lsl_pkg::MODE_GLOBAL:      next_mode = lsl_pkg::MODE_OVERTEMP;
            lsl_pkg::MODE_OVERTEMP:    next_mode = lsl_pkg::MODE_OPEN;
            lsl_pkg::MODE_OPEN:        next_mode = lsl_pkg::MODE_SHORT;
            lsl_pkg::MODE_SHORT:       next_mode = lsl_pkg::MODE_LOW_CURRENT;
            lsl_pkg::MODE_LOW_CURRENT: next_mode = lsl_pkg::MODE_GLOBAL;
            default:                   next_mode = lsl_pkg::MODE_GLOBAL;
        endcase
    endfunction

    // Gather pins; reset values keep gate off and clocks idle
    always_comb begin
        pins_raw.serial_clock    = serial_clock_i;
        pins_raw.serial_data     = serial_in_i;
        pins_raw.latch_strobe    = latch_strobe_i;
        pins_raw.gate_n          = drive_gate_n_i;
        pins_raw.error_mode      = error_mode_i;
        pins_raw.sense.overtemp  = overtemp_i;
        pins_raw.sense.open_led  = open_sense_i;
        pins_raw.sense.short_led = short_sense_i;
        pins_rst                 = '0;
        pins_rst.gate_n          = `LSL_GATE_RST;
    end

    // Two flops on every pin before any logic reads it
    sync_bits #(
        .WIDTH     ($bits(lsl_pkg::pin_bundle_t))
    ) u_sync (
        .clock_i   (clock_i),
        .nrst_i    (nrst_i),
        .async_i   (pins_raw),
        .rst_val_i (pins_rst),
        .sync_o    (pins)
    );

    // Edge history of the synchronised serial clock and strobe
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            sclk_prev_q   <= 1'h0;
            strobe_prev_q <= 1'h0;
        end else begin
            sclk_prev_q   <= pins.serial_clock;
            strobe_prev_q <= pins.latch_strobe;
        end
    end

    assign sclk_rise   = pins.serial_clock && !sclk_prev_q;
    assign sclk_fall   = !pins.serial_clock && sclk_prev_q;
    assign strobe_rise = pins.latch_strobe && !strobe_prev_q;
    assign any_fault   = pins.sense.overtemp || (|pins.sense.open_led)
                         || (|pins.sense.short_led);

    // Mode: pin enters diagnostics, serial rises step through them
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            mode_q <= lsl_pkg::MODE_NORMAL;
        end else if (!pins.error_mode) begin
            mode_q <= lsl_pkg::MODE_NORMAL;
        end else if (mode_q == lsl_pkg::MODE_NORMAL) begin
            mode_q <= lsl_pkg::MODE_GLOBAL;
        end else if (sclk_rise) begin
            mode_q <= next_mode(mode_q);
        end
    end

    // Shift on rising edge in normal mode; last bit spills out
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            shift_q <= `LSL_DATA_RST;
            spill_q <= 1'h0;
        end else if (sclk_rise && mode_q == lsl_pkg::MODE_NORMAL) begin
            shift_q <= {shift_q[NCH-2:0], pins.serial_data};
            spill_q <= shift_q[NCH-1];
        end
    end

    // Serial output: shifted data on falling edge, or fault report
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            chain_q <= `LSL_CHAIN_RST;
        end else begin
            unique case (mode_q)
                lsl_pkg::MODE_NORMAL: begin
                    if (sclk_fall) begin
                        chain_q <= spill_q;
                    end
                end
                lsl_pkg::MODE_GLOBAL:
                    chain_q <= !global_fault_q;
                lsl_pkg::MODE_OVERTEMP:
                    chain_q <= !result_q.overtemp;
                lsl_pkg::MODE_OPEN:
                    chain_q <= !(|result_q.open_led);
                lsl_pkg::MODE_SHORT:
                    chain_q <= !(|result_q.short_led);
                lsl_pkg::MODE_LOW_CURRENT:
                    chain_q <= !global_fault_q;
            endcase
        end
    end

    // Loaded frames queue here, up to BUF_DEPTH, while the driver stage is busy; a load into a full queue is dropped
    pair_buffer #(
        .WIDTH       (NCH),
        .DEPTH       (BUF_DEPTH)
    ) u_buf (
        .clock_i     (clock_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (strobe_rise),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (shift_q),
        .out_valid_o (buf_out_valid),
        .out_ready_i (sink_ready_i),
        .out_data_o  (buf_out_data)
    );

    // Data register changes only when a queued frame is taken
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            data_q <= `LSL_DATA_RST;
        end else if (buf_out_valid && sink_ready_i) begin
            data_q <= buf_out_data;
        end
    end

    // A load that finds the queue full is flagged for one cycle
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            overrun_q <= 1'h0;
        end else begin
            overrun_q <= strobe_rise && !buf_in_ready;
        end
    end

    // Faults recorded at each load, channels acting as sense inputs
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            global_fault_q <= 1'h0;
            result_q       <= '0;
        end else if (strobe_rise) begin
            global_fault_q <= any_fault;
            result_q       <= pins.sense;
        end
    end

    // One sink per data bit, gated in every mode
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            sink_q <= `LSL_DATA_RST;
        end else if (pins.gate_n) begin
            sink_q <= '0;
        end else begin
            sink_q <= data_q;
        end
    end

    // Reduced test current while in the low-current mode
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            low_cur_q <= 1'h0;
        end else begin
            low_cur_q <= (mode_q == lsl_pkg::MODE_LOW_CURRENT);
        end
    end

    // Outputs straight from flops
    assign sink_channel_o = sink_q;
    assign chain_out_o    = chain_q;
    assign low_current_o  = low_cur_q;
    assign mode_o         = mode_q;
    assign diag_result_o  = result_q;
    assign global_fault_o = global_fault_q;
    assign overrun_o      = overrun_q;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_normal_rise;
        sclk_rise && mode_q == lsl_pkg::MODE_NORMAL;
    endsequence

    sequence s_frame_taken;
        buf_out_valid && sink_ready_i;
    endsequence

    sequence s_normal_fall;
        sclk_fall && mode_q == lsl_pkg::MODE_NORMAL;
    endsequence

    a_shift_capture: assert property (
        s_normal_rise |=> shift_q == {$past(shift_q[NCH-2:0]),
                                       $past(pins.serial_data)})
        else $error("shift register did not capture serial bit");

    // Oldest bit spills at the rise, then leaves on the next fall
    a_spill_bit: assert property (
        s_normal_rise |=> spill_q == $past(shift_q[NCH-1]))
        else $error("oldest bit not kept for the chain output");

    a_chain_delay: assert property (
        s_normal_fall |=> chain_q == $past(spill_q))
        else $error("chain output not launched on falling edge");

    a_mode_step: assert property (
        sclk_rise && pins.error_mode && mode_q != lsl_pkg::MODE_NORMAL
        |=> mode_q == next_mode($past(mode_q)) && $stable(shift_q))
        else $error("error mode did not advance");

    a_load_queued: assert property (
        strobe_rise && buf_in_ready && !buf_out_valid && sink_ready_i
        |=> ##1 data_q == $past(shift_q, 2))
        else $error("load did not reach data register");

    a_data_hold: assert property (
        !(buf_out_valid && sink_ready_i) |=> $stable(data_q))
        else $error("data register changed without a load");

    a_frame_load: assert property (
        s_frame_taken |=> data_q == $past(buf_out_data))
        else $error("queued frame not copied to data register");

    a_gate_off: assert property (
        pins.gate_n |=> sink_q == '0)
        else $error("sinks on while gate is high");

    a_gate_any_mode: assert property (
        !pins.gate_n && mode_q != lsl_pkg::MODE_NORMAL
        |=> sink_q == $past(data_q))
        else $error("gate failed to enable sinks in diagnostic mode");

    a_global_flag: assert property (
        mode_q == lsl_pkg::MODE_GLOBAL && $stable(global_fault_q)
        |=> chain_q == !$past(global_fault_q))
        else $error("global flag not shown on chain output");

    a_fault_record: assert property (
        strobe_rise |=> global_fault_q == $past(any_fault)
                        && result_q == $past(pins.sense))
        else $error("fault status not recorded at load");

    a_low_current: assert property (
        mode_q == lsl_pkg::MODE_LOW_CURRENT ##1
        mode_q == lsl_pkg::MODE_LOW_CURRENT |-> low_cur_q)
        else $error("low current not asserted in its mode");

    a_overrun_flag: assert property (
        strobe_rise && !buf_in_ready |=> overrun_q)
        else $error("dropped load not flagged");

endmodule

`default_nettype wire

// ### hdl/lsl_consts.svh
// Purpose: Constants for the LED sink shift and latch block
// Assumes: Included by the package and by the top-level design file
// Notes:   Definitions only; guarded against double inclusion
`ifndef LSL_CONSTS_SVH
`define LSL_CONSTS_SVH

`define LSL_CHANNELS     8
`define LSL_SYNC_STAGES  2
`define LSL_BUF_DEPTH    2
`define LSL_DATA_RST     8'h00
`define LSL_CHAIN_RST    1'h1
`define LSL_GATE_RST     1'h1

`endif

// ### hdl/lsl_pkg.sv
// Purpose: Types shared by the LED sink shift and latch design
// Assumes: lsl_consts.svh gives the channel count
// Notes:   Types only; numbers live in the header
`include "lsl_consts.svh"

package lsl_pkg;

    // Operating modes; diagnostic modes cycle on serial clock rises
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_GLOBAL,
        MODE_OVERTEMP,
        MODE_OPEN,
        MODE_SHORT,
        MODE_LOW_CURRENT
    } diag_mode_t;

    // Fault results captured at each load
    typedef struct packed {
        logic                       overtemp;
        logic [`LSL_CHANNELS-1:0]   open_led;
        logic [`LSL_CHANNELS-1:0]   short_led;
    } diag_result_t;

    // All asynchronous pin inputs, synchronised as one bundle
    typedef struct packed {
        logic                       serial_clock;
        logic                       serial_data;
        logic                       latch_strobe;
        logic                       gate_n;
        logic                       error_mode;
        diag_result_t               sense;
    } pin_bundle_t;

endpackage

// ### hdl/pair_buffer.sv
// Purpose: Small FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two, at least two
// Notes:   Full refuses pushes; empty offers nothing
`timescale 1ns/10ps
`default_nettype none

module pair_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clock_i,   // System clock
    input  wire logic             nrst_i,    // Sync reset, active low
    input  wire logic             in_valid_i,// Word offered
    output logic                  in_ready_o,// Space available
    input  wire logic [WIDTH-1:0] in_data_i, // Word in
    output logic                  out_valid_o,// Word available
    input  wire logic             out_ready_i,// Sink takes word
    output logic      [WIDTH-1:0] out_data_o // Word out
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // Handshake terms and flags
    assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = store_q[rd_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage written at the write index
    always_ff @(posedge clock_i) begin
        if (push) begin
            store_q[wr_q] <= in_data_i;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule

`default_nettype wire

// ### hdl/sync_bits.sv
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none

module sync_bits #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_i,   // System clock
    input  wire logic             nrst_i,    // Sync reset, active low
    input  wire logic [WIDTH-1:0] async_i,   // Pin levels
    input  wire logic [WIDTH-1:0] rst_val_i, // Value held in reset
    output logic      [WIDTH-1:0] sync_o     // Synchronised levels
);

    logic [WIDTH-1:0] meta_q;

    // Two stages; reset loads constants from the parent
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            meta_q <= rst_val_i;
            sync_o <= rst_val_i;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ### verification/host_ctrl.sv
// Purpose: Host controller model that drives the serial pins
// Assumes: Pins change just after a rising clock_i edge
// Notes:   Serial clock stands low outside frames
`timescale 1ns/10ps
`default_nettype none

module host_ctrl (
    input  wire logic clock_i,        // System clock
    input  wire logic chain_i,        // Device chain output
    output logic      serial_data_o,  // Serial data pin
    output logic      serial_clock_o, // Serial clock pin
    output logic      latch_strobe_o  // Load strobe pin
);
    // Idle pin levels at time zero
    initial begin
        serial_data_o  = 1'b0;
        serial_clock_o = 1'b0;
        latch_strobe_o = 1'b0;
    end

    // One bit: data held across the rise, chain sampled after the fall
    task automatic shift_bit(input logic b, output logic seen);
        serial_data_o <= b;
        repeat (4) @(posedge clock_i);
        serial_clock_o <= 1'b1;
        repeat (4) @(posedge clock_i);
        serial_clock_o <= 1'b0;
        repeat (4) @(posedge clock_i);
        seen = chain_i;
    endtask

    // Eight bits a device, channel 7 first; data turned over afterwards
    task automatic send_frame(input logic [7:0] v, output logic [7:0] seen);
        for (int i = 7; i >= 0; i--) begin
            shift_bit(v[i], seen[i]);
        end
        serial_data_o <= ~v[0];
    endtask

    // Strobe after a whole frame, two levels of four clocks
    task automatic strobe();
        latch_strobe_o <= 1'b1;
        repeat (4) @(posedge clock_i);
        latch_strobe_o <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask

    // Bare serial clock pulse, used to step the diagnostic modes
    task automatic step_clock();
        serial_clock_o <= 1'b1;
        repeat (4) @(posedge clock_i);
        serial_clock_o <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Purpose: Self-checking bench for the LED sink shift and latch block
// Assumes: host_ctrl drives the serial pins, the bench the rest
// Notes:   Pin levels last four clocks so the synchronisers see them
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic                  clock_i;
    logic                  nrst_i;
    logic                  serial_in_i;
    logic                  serial_clock_i;
    logic                  latch_strobe_i;
    logic                  drive_gate_n_i;
    logic                  error_mode_i;
    logic                  overtemp_i;
    logic [7:0]            open_sense_i;
    logic [7:0]            short_sense_i;
    logic                  sink_ready_i;
    logic [7:0]            sink_channel_o;
    logic                  chain_out_o;
    logic                  low_current_o;
    lsl_pkg::diag_mode_t   mode_o;
    lsl_pkg::diag_result_t diag_result_o;
    logic                  global_fault_o;
    logic                  overrun_o;
    logic [7:0]            seen;
    int                    n_mismatch;
    int                    samples_checked;
    int                    n_ovr;

    led_sink_shift_latch #(.BUF_DEPTH(2)) i_dut (
        .clock_i        (clock_i),
        .nrst_i         (nrst_i),
        .serial_in_i    (serial_in_i),
        .serial_clock_i (serial_clock_i),
        .latch_strobe_i (latch_strobe_i),
        .drive_gate_n_i (drive_gate_n_i),
        .error_mode_i   (error_mode_i),
        .overtemp_i     (overtemp_i),
        .open_sense_i   (open_sense_i),
        .short_sense_i  (short_sense_i),
        .sink_ready_i   (sink_ready_i),
        .sink_channel_o (sink_channel_o),
        .chain_out_o    (chain_out_o),
        .low_current_o  (low_current_o),
        .mode_o         (mode_o),
        .diag_result_o  (diag_result_o),
        .global_fault_o (global_fault_o),
        .overrun_o      (overrun_o)
    );

    host_ctrl i_host (
        .clock_i        (clock_i),
        .chain_i        (chain_out_o),
        .serial_data_o  (serial_in_i),
        .serial_clock_o (serial_clock_i),
        .latch_strobe_o (latch_strobe_i)
    );

    // 25 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // Counts dropped-load pulses, which last a single cycle
    always @(posedge clock_i) begin
        if (overrun_o === 1'b1) begin
            n_ovr++;
        end
    end

    // Compares one value and reports a mismatch at once
    task automatic check(input string name, input logic [16:0] got,
                         input logic [16:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Frame loads while gated off, then the gate toggles
    task automatic t_load_gate();
        i_host.send_frame(8'hA5, seen);
        i_host.strobe();
        check("sinks gated", 17'(sink_channel_o), 17'h0);
        drive_gate_n_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        check("sinks on", 17'(sink_channel_o), 17'hA5);
        drive_gate_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        check("sinks off", 17'(sink_channel_o), 17'h0);
        drive_gate_n_i <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask

    // Shifting alone keeps the pattern; old frame spills on the chain
    task automatic t_hold_chain();
        i_host.send_frame(8'h3C, seen);
        check("chain spill", 17'(seen), 17'hA5);
        check("sinks held", 17'(sink_channel_o), 17'hA5);
        i_host.strobe();
        check("sinks new", 17'(sink_channel_o), 17'h3C);
    endtask

    // Fault capture, then a full lap of the diagnostic modes
    task automatic t_diag();
        lsl_pkg::diag_mode_t exp_mode [5];
        logic                exp_chain [5];
        exp_mode  = '{lsl_pkg::MODE_OVERTEMP, lsl_pkg::MODE_OPEN,
                      lsl_pkg::MODE_SHORT, lsl_pkg::MODE_LOW_CURRENT,
                      lsl_pkg::MODE_GLOBAL};
        exp_chain = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        overtemp_i   <= 1'b1;
        open_sense_i <= 8'h81;
        i_host.strobe();
        check("fault", 17'(global_fault_o), 17'h1);
        check("result", 17'(diag_result_o), {1'b1, 8'h81, 8'h00});
        error_mode_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        check("mode", 17'(mode_o), 17'(lsl_pkg::MODE_GLOBAL));
        check("global flag", 17'(chain_out_o), 17'h0);
        for (int k = 0; k < 5; k++) begin
            i_host.step_clock();
            check("mode", 17'(mode_o), 17'(exp_mode[k]));
            check("flag", 17'(chain_out_o), 17'(exp_chain[k]));
            check("low", 17'(low_current_o), 17'(k == 3));
            check("sinks", 17'(sink_channel_o), 17'h3C);
        end
        overtemp_i   <= 1'b0;
        open_sense_i <= 8'h00;
        i_host.strobe();
        check("no fault", 17'(chain_out_o), 17'h1);
        error_mode_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        check("normal", 17'(mode_o), 17'(lsl_pkg::MODE_NORMAL));
    endtask

    // Driver stalls: two frames wait, the third is dropped
    task automatic t_overrun();
        sink_ready_i <= 1'b0;
        i_host.send_frame(8'h11, seen);
        i_host.strobe();
        i_host.send_frame(8'h22, seen);
        i_host.strobe();
        i_host.send_frame(8'h33, seen);
        i_host.strobe();
        check("stalled", 17'(sink_channel_o), 17'h3C);
        check("overrun", 17'(n_ovr), 17'h1);
        sink_ready_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        check("drained", 17'(sink_channel_o), 17'h22);
    endtask

    // Reset, then the scenarios in turn
    initial begin
        nrst_i          = 1'b0;
        drive_gate_n_i  = 1'b1;
        error_mode_i    = 1'b0;
        overtemp_i      = 1'b0;
        open_sense_i    = 8'h00;
        short_sense_i   = 8'h00;
        sink_ready_i    = 1'b1;
        n_mismatch      = 0;
        samples_checked = 0;
        n_ovr           = 0;
        repeat (3) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        check("reset sinks", 17'(sink_channel_o), 17'h0);
        check("reset chain", 17'(chain_out_o), 17'h1);
        t_load_gate();
        t_hold_chain();
        t_diag();
        t_overrun();
        stop_test();
    end

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        stop_test();
    end
endmodule
`default_nettype wire
